// ### cpp_core_port_ctrl.sv
`timescale 1ns/1ps
module cpp_core_port_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire cpp_pkg::cpp_bus_type bus,
  input wire logic [2:0] mode_in,
  input wire logic secure,
  input wire cpp_pkg::cpp_dir_type dirs,
  input wire logic irq_pin,
  input wire logic irq_service,
  output logic [7:0] rdata,
  output logic bus_external,
  output cpp_pkg::cpp_pull_type pulls,
  output logic [3:0] low_drive,
  output logic bus_e_clock_stretch_active,
  output logic irq_request,
  output logic irq_edge_sel_out,
  output logic irq_pin_connect_out
);
  import cpp_pkg::*;

  logic special;
  logic single_chip;
  logic mapped;
  logic [7:0] pull_reg;
  logic [7:0] drive_reg;
  logic bus_e_clock_stretch_sel_reg;
  logic stretch_done_reg;
  logic irq_edge_sel_reg;
  logic edge_done_reg;
  logic irq_pin_connect_reg;
  logic irq_pin_prev_reg;
  logic edge_latch_reg;
  logic [2:0] mode_reg;
  logic in_reset;
  logic wr_map;
  logic rd_map;
  logic [7:0] rdata_next;
  logic [7:0] pull_e_forced;
  logic [7:0] pull_a_w;
  logic [7:0] pull_b_w;
  logic [7:0] pull_e_w;
  logic [7:0] pull_k_w;

  cpp_mode_decode u_decode (
    .mode_in(mode_reg),
    .special(special),
    .single_chip(single_chip),
    .mapped(mapped)
  );

  // Mode field mirror is writable only where allowed and never when secure
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_reg <= mode_in;
    end else if (bus.wr && bus.addr == ADDR_MODE && mapped && !secure) begin
      if (special && bus.wdata[7:BIT_MODE_LO] != MODE_SPECIAL_PERIPH) begin
        mode_reg <= bus.wdata[7:BIT_MODE_LO];
      end
    end else if (!(special && mapped)) begin
      mode_reg <= mode_in;
    end
  end

  assign in_reset = !rst_n;
  assign wr_map = bus.wr && mapped;
  assign rd_map = bus.rd && mapped;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pull_reg <= PULL_RESET;
    end else if (wr_map && bus.addr == ADDR_PULL) begin
      pull_reg <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive_reg <= DRIVE_RESET;
    end else if (wr_map && bus.addr == ADDR_DRIVE) begin
      drive_reg <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_e_clock_stretch_sel_reg <= STRETCH_RESET;
      stretch_done_reg <= 1'b0;
    end else if (wr_map && bus.addr == ADDR_STRETCH) begin
      if (special || !stretch_done_reg) begin
        bus_e_clock_stretch_sel_reg <= bus.wdata[BIT_STRETCH];
      end
      stretch_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_edge_sel_reg <= EDGE_RESET;
      edge_done_reg <= 1'b0;
      irq_pin_connect_reg <= CONNECT_RESET;
    end else if (wr_map && bus.addr == ADDR_IRQ) begin
      if (special || !edge_done_reg) begin
        irq_edge_sel_reg <= bus.wdata[BIT_EDGE];
      end
      edge_done_reg <= 1'b1;
      irq_pin_connect_reg <= bus.wdata[BIT_CONNECT];
    end
  end

  // Falling edge latch; a new edge wins over a service in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_pin_prev_reg <= 1'b1;
      edge_latch_reg <= 1'b0;
    end else begin
      irq_pin_prev_reg <= irq_pin;
      if (!irq_pin_connect_reg) begin
        edge_latch_reg <= 1'b0;
      end else if (irq_edge_sel_reg && irq_pin_prev_reg && !irq_pin) begin
        edge_latch_reg <= 1'b1;
      end else if (irq_service) begin
        edge_latch_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_request <= 1'b0;
    end else if (!irq_pin_connect_reg) begin
      irq_request <= 1'b0;
    end else if (irq_edge_sel_reg) begin
      irq_request <= edge_latch_reg ||
        (irq_pin_prev_reg && !irq_pin);
    end else begin
      irq_request <= !irq_pin;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (rd_map) begin
      case (bus.addr)
        ADDR_PULL: rdata_next = pull_reg;
        ADDR_DRIVE: rdata_next = drive_reg;
        ADDR_STRETCH: rdata_next = {7'h00, bus_e_clock_stretch_sel_reg};
        ADDR_RSVD: rdata_next = 8'h00;
        ADDR_IRQ: rdata_next = {irq_edge_sel_reg, irq_pin_connect_reg,
          6'h00};
        ADDR_MODE: rdata_next = {mode_reg, 5'h00};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      bus_external <= 1'b0;
    end else begin
      rdata <= rdata_next;
      bus_external <= (bus.wr || bus.rd) && !mapped;
    end
  end

  assign pull_e_forced = in_reset ? PORT_E_RESET_PULL : 8'h00;

  cpp_port_pull u_pull_a (
    .dir(dirs.dir_a),
    .allowed(8'hff),
    .forced(8'h00),
    .enable(pull_reg[BIT_A]),
    .pull(pull_a_w)
  );
  cpp_port_pull u_pull_b (
    .dir(dirs.dir_b),
    .allowed(8'hff),
    .forced(8'h00),
    .enable(pull_reg[BIT_B]),
    .pull(pull_b_w)
  );
  cpp_port_pull u_pull_e (
    .dir(dirs.dir_e),
    .allowed(PORT_E_CTRL_PULL),
    .forced(pull_e_forced),
    .enable(pull_reg[BIT_E]),
    .pull(pull_e_w)
  );
  cpp_port_pull u_pull_k (
    .dir(dirs.dir_k),
    .allowed(8'hff),
    .forced(8'h00),
    .enable(pull_reg[BIT_K]),
    .pull(pull_k_w)
  );

  // Registered outputs; pins 5 and 6 of port E also pull during reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulls <= '{pull_a: 8'h00, pull_b: 8'h00, pull_e: PORT_E_RESET_PULL,
        pull_k: 8'h00};
      low_drive <= 4'h0;
      bus_e_clock_stretch_active <= 1'b0;
      irq_edge_sel_out <= EDGE_RESET;
      irq_pin_connect_out <= CONNECT_RESET;
    end else begin
      pulls <= '{pull_a: pull_a_w, pull_b: pull_b_w, pull_e: pull_e_w,
        pull_k: pull_k_w};
      // Drive strength is per port, independent of pin function
      low_drive <= {drive_reg[BIT_K], drive_reg[BIT_E], drive_reg[BIT_B],
        drive_reg[BIT_A]};
      bus_e_clock_stretch_active <= bus_e_clock_stretch_sel_reg && !single_chip;
      irq_edge_sel_out <= irq_edge_sel_reg;
      irq_pin_connect_out <= irq_pin_connect_reg;
    end
  end

endmodule : cpp_core_port_ctrl

// ### cpp_pkg.sv
package cpp_pkg;
  localparam logic [7:0] ADDR_PULL = 8'h0c;
  localparam logic [7:0] ADDR_DRIVE = 8'h0d;
  localparam logic [7:0] ADDR_STRETCH = 8'h0e;
  localparam logic [7:0] ADDR_RSVD = 8'h0f;
  localparam logic [7:0] ADDR_IRQ = 8'h1e;
  localparam logic [7:0] ADDR_MODE = 8'h0b;
  localparam int BIT_K = 7;
  localparam int BIT_E = 4;
  localparam int BIT_B = 1;
  localparam int BIT_A = 0;
  localparam int BIT_STRETCH = 0;
  localparam int BIT_EDGE = 7;
  localparam int BIT_CONNECT = 6;
  localparam int BIT_MODE_LO = 5;
  localparam logic [7:0] PULL_RESET = 8'h90;
  localparam logic [7:0] DRIVE_RESET = 8'h00;
  localparam logic STRETCH_RESET = 1'b0;
  localparam logic EDGE_RESET = 1'b0;
  localparam logic CONNECT_RESET = 1'b1;
  localparam logic [7:0] PORT_E_RESET_PULL = 8'h60;
  localparam logic [7:0] PORT_E_CTRL_PULL = 8'h9f;

  typedef enum logic [2:0] {
    MODE_SPECIAL_SINGLE = 3'b000,
    MODE_EMUL_NARROW = 3'b001,
    MODE_SPECIAL_TEST = 3'b010,
    MODE_EMUL_WIDE = 3'b011,
    MODE_NORMAL_SINGLE = 3'b100,
    MODE_NORMAL_NARROW = 3'b101,
    MODE_SPECIAL_PERIPH = 3'b110,
    MODE_NORMAL_WIDE = 3'b111
  } cpp_mode_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cpp_bus_type;

  typedef struct packed {
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_e;
    logic [7:0] dir_k;
  } cpp_dir_type;

  typedef struct packed {
    logic [7:0] pull_a;
    logic [7:0] pull_b;
    logic [7:0] pull_e;
    logic [7:0] pull_k;
  } cpp_pull_type;
endpackage : cpp_pkg

// ### cpp_mode_decode.sv
`timescale 1ns/1ps
module cpp_mode_decode (
  input wire logic [2:0] mode_in,
  output logic special,
  output logic single_chip,
  output logic mapped
);
  import cpp_pkg::*;
  cpp_mode_type mode;
  always_comb begin
    mode = cpp_mode_type'(mode_in);
    special = 1'b0;
    single_chip = 1'b0;
    mapped = 1'b0;
    case (mode)
      MODE_SPECIAL_SINGLE: begin
        special = 1'b1;
        single_chip = 1'b1;
        mapped = 1'b1;
      end
      MODE_SPECIAL_TEST: begin
        special = 1'b1;
        mapped = 1'b1;
      end
      MODE_NORMAL_SINGLE: begin
        single_chip = 1'b1;
        mapped = 1'b1;
      end
      MODE_SPECIAL_PERIPH: begin
        special = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end
endmodule : cpp_mode_decode

// ### cpp_port_pull.sv
`timescale 1ns/1ps
module cpp_port_pull (
  input wire logic [7:0] dir,
  input wire logic [7:0] allowed,
  input wire logic [7:0] forced,
  input wire logic enable,
  output logic [7:0] pull
);
  // Direction bit high means output; outputs never pull
  assign pull = ~dir & ((allowed & {8{enable}}) | forced);
endmodule : cpp_port_pull

// ### cpp_core_port_ctrl_assertions.sv
`timescale 1ns/1ps
module cpp_core_port_ctrl_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire cpp_pkg::cpp_bus_type bus,
  input wire logic [2:0] mode_in,
  input wire logic secure,
  input wire cpp_pkg::cpp_dir_type dirs,
  input wire logic irq_pin,
  input wire logic irq_service,
  input wire logic [7:0] rdata,
  input wire logic bus_external,
  input wire cpp_pkg::cpp_pull_type pulls,
  input wire logic [3:0] low_drive,
  input wire logic bus_e_clock_stretch_active,
  input wire logic irq_request,
  input wire logic irq_edge_sel_out,
  input wire logic irq_pin_connect_out
);
  import cpp_pkg::*;
  logic unmap;
  logic single;
  logic conn;
  logic esel;
  assign unmap = mode_in[0] | (mode_in == 3'b110);
  assign single = mode_in[1:0] == 2'b00;
  assign conn = irq_pin_connect_out;
  assign esel = irq_edge_sel_out;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_echo_unmapped: assert property (
    bus_external == $past((bus.wr | bus.rd) & unmap))
    else $error("echo pulse wrong");
  a_unmapped_silent: assert property (
    bus.rd && unmap |=> rdata == 8'h00) else $error("unmapped read data");
  a_reserved_zero: assert property (
    bus.rd && bus.addr == ADDR_RSVD |=> rdata == 8'h00)
    else $error("reserved read not zero");
  a_stretch_single: assert property (
    single && $past(single) && $past(single, 2) |-> !bus_e_clock_stretch_active)
    else $error("stretch active in single chip");
  a_pull_on_output: assert property (
    (pulls.pull_k & $past(dirs.dir_k)) == 8'h00 &&
    (pulls.pull_a & $past(dirs.dir_a)) == 8'h00) else $error("pull on output");
  a_disconnect_quiet: assert property (
    !conn && !$past(conn) |-> !irq_request) else $error("request while cut");
  a_level_request: assert property (
    conn && $past(conn) && !esel && !$past(esel) && !$past(irq_pin)
    |-> irq_request) else $error("low level not seen");
  a_edge_hold: assert property (
    irq_request && esel && conn && !irq_service |=> irq_request)
    else $error("edge latch lost");
endmodule : cpp_core_port_ctrl_chk
bind cpp_core_port_ctrl cpp_core_port_ctrl_chk u_chk (.clk(clk), .rst_n(rst_n),
  .bus(bus), .mode_in(mode_in), .secure(secure), .dirs(dirs),
  .irq_pin(irq_pin), .irq_service(irq_service), .rdata(rdata),
  .bus_external(bus_external), .pulls(pulls), .low_drive(low_drive),
  .bus_e_clock_stretch_active(bus_e_clock_stretch_active), .irq_request(irq_request),
  .irq_edge_sel_out(irq_edge_sel_out),
  .irq_pin_connect_out(irq_pin_connect_out));

// ### cpp_irq_partner.sv
`timescale 1ns/1ps
module cpp_irq_partner (
  input wire logic low_cmd,
  input wire logic svc_en,
  input wire logic irq_request,
  output logic irq_pin,
  output logic irq_service
);
  // Pin has a pull-up: high unless the source pulls it low
  assign irq_pin = ~low_cmd;
  // Services only an interrupt that is pending
  assign irq_service = svc_en & irq_request;
endmodule : cpp_irq_partner

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import cpp_pkg::*;
  logic clk, rst_n, secure, irq_pin, irq_service, low_cmd, svc_en;
  logic bus_external, bus_e_clock_stretch_active, irq_request, esel, conn;
  logic [2:0] mode_in;
  logic [3:0] low_drive;
  logic [7:0] rdata;
  cpp_bus_type bus;
  cpp_dir_type dirs;
  cpp_pull_type pulls;
  int n_mismatch, samples_checked;
  int bits[4] = '{0, 1, 4, 7};
  cpp_core_port_ctrl DUT (.clk(clk), .rst_n(rst_n), .bus(bus),
    .mode_in(mode_in), .secure(secure), .dirs(dirs), .irq_pin(irq_pin),
    .irq_service(irq_service), .rdata(rdata), .bus_external(bus_external),
    .pulls(pulls), .low_drive(low_drive),
    .bus_e_clock_stretch_active(bus_e_clock_stretch_active), .irq_request(irq_request),
    .irq_edge_sel_out(esel), .irq_pin_connect_out(conn));
  cpp_irq_partner u_far (.low_cmd(low_cmd), .svc_en(svc_en),
    .irq_request(irq_request), .irq_pin(irq_pin), .irq_service(irq_service));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
    @(posedge clk);
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk({24'h0, rdata & m}, {24'h0, e});
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic rst_to(input logic [2:0] m);
    @(posedge clk);
    rst_n <= 1'b0;
    mode_in <= m;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : rst_to
  task automatic conclude;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    {rst_n, secure, low_cmd, svc_en} = 4'h0;
    bus = '0;
    mode_in = 3'b000;
    dirs = '0;
    rst_to(3'b000);
    rd(ADDR_PULL, 8'h93, PULL_RESET);
    rd(ADDR_DRIVE, 8'h93, DRIVE_RESET);
    rd(ADDR_IRQ, 8'hc0, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PULL, 8'h01 << bits[i]);
      wr(ADDR_DRIVE, 8'h01 << bits[i]);
      rd(ADDR_DRIVE, 8'h93, 8'h01 << bits[i]);
      chk(pulls, (32'hff00_0000 >> (8 * i)) & 32'hffff_9fff);
      chk({28'h0, low_drive}, 32'h1 << i);
    end
    dirs <= '{dir_a: 8'h0f, dir_b: 8'h00, dir_e: 8'h81, dir_k: 8'hf0};
    wr(ADDR_PULL, 8'h93);
    settle;
    chk(pulls, {8'hf0, 8'hff, 8'h1e, 8'h0f});
    wr(ADDR_RSVD, 8'hff);
    rd(ADDR_RSVD, 8'hff, 8'h00);
    wr(ADDR_STRETCH, 8'h01);
    wr(ADDR_STRETCH, 8'h00);
    wr(ADDR_STRETCH, 8'h01);
    rd(ADDR_STRETCH, 8'h01, 8'h01);
    chk(bus_e_clock_stretch_active, 1'b0);
    secure <= 1'b1;
    wr(ADDR_MODE, 8'h40);
    rd(ADDR_MODE, 8'he0, 8'h00);
    secure <= 1'b0;
    rst_to(3'b010);
    wr(ADDR_STRETCH, 8'h01);
    settle;
    chk(bus_e_clock_stretch_active, 1'b1);
    rst_to(3'b100);
    wr(ADDR_STRETCH, 8'h01);
    wr(ADDR_STRETCH, 8'h00);
    rd(ADDR_STRETCH, 8'h01, 8'h01);
    wr(ADDR_IRQ, 8'hc0);
    wr(ADDR_IRQ, 8'h40);
    rd(ADDR_IRQ, 8'hc0, 8'hc0);
    chk({30'h0, esel, conn}, 32'h3);
    chk(bus_e_clock_stretch_active, 1'b0);
    wr(ADDR_PULL, 8'h93);
    mode_in <= 3'b101;
    wr(ADDR_PULL, 8'h00);
    #1 chk({31'h0, bus_external}, 32'h1);
    mode_in <= 3'b100;
    rd(ADDR_PULL, 8'h93, 8'h93);
    rst_to(3'b000);
    low_cmd <= 1'b1;
    settle;
    chk(irq_request, 1'b1);
    low_cmd <= 1'b0;
    settle;
    chk(irq_request, 1'b0);
    wr(ADDR_IRQ, 8'hc0);
    low_cmd <= 1'b1;
    settle;
    low_cmd <= 1'b0;
    settle;
    chk(irq_request, 1'b1);
    svc_en <= 1'b1;
    settle;
    chk(irq_request, 1'b0);
    svc_en <= 1'b0;
    wr(ADDR_IRQ, 8'h80);
    low_cmd <= 1'b1;
    settle;
    low_cmd <= 1'b0;
    settle;
    chk(irq_request, 1'b0);
    wr(ADDR_IRQ, 8'h00);
    low_cmd <= 1'b1;
    settle;
    chk(irq_request, 1'b0);
    conclude;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    conclude;
  end
endmodule : testbench
